//--- sai_receiver.sv
// Receiving end: decodes the serial audio frame into tagged samples
`timescale 1ns/1ns
`include "sai_consts.svh"
module sai_receiver
(
	input wire logic clk,
	input wire logic resetn,
	sai_link_if.receiver link,
	input wire sai_pkg::sai_fmt_t cfg_format,
	input wire logic [5:0] cfg_len,
	output logic sample_valid,
	output logic [31:0] sample_data,
	output logic [3:0] sample_slot,
	output logic [15:0] mclk_ratio,
	output sai_pkg::sai_div_t clk_div_sel,
	output logic mclk_rate_ok
);
	import sai_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State

	logic sclk_prev_reg, sclk_prev_next;
	logic fs_last_reg, fs_last_next;
	logic armed_reg, armed_next;
	logic running_reg, running_next;
	logic [5:0] pos_reg, pos_next;
	logic [3:0] slot_reg, slot_next;
	logic [31:0] shreg_reg, shreg_next;
	logic valid_reg, valid_next;
	logic [31:0] data_reg, data_next;
	logic [3:0] tag_reg, tag_next;

	logic rise;
	logic fs;
	logic sd;
	logic fs_chg;
	logic fs_up;
	logic start_edge;
	logic [5:0] cur_pos;
	logic [3:0] cur_slot;
	logic [5:0] slot_w;
	logic [3:0] slot_n;
	logic frame_tick;

	assign fs = link.frame_sync_in;
	assign sd = link.serial_data_in;
	assign rise = link.serial_bit_clock && !sclk_prev_reg;
	assign fs_chg = fs != fs_last_reg;
	assign fs_up = fs && !fs_last_reg;
	assign slot_w = sai_slot_width(cfg_format);
	assign slot_n = sai_slot_count(cfg_format);
	assign frame_tick = rise && fs_up;

	////////////////////////////////////////////////////////////////////////////
	// Frame decode

	always_comb
	begin
		sclk_prev_next = link.serial_bit_clock;
		fs_last_next = fs_last_reg;
		armed_next = armed_reg;
		running_next = running_reg;
		pos_next = pos_reg;
		slot_next = slot_reg;
		shreg_next = shreg_reg;
		valid_next = 1'b0;
		data_next = data_reg;
		tag_next = tag_reg;
		start_edge = 1'b0;
		cur_pos = pos_reg;
		cur_slot = slot_reg;
		if (rise)
		begin
			fs_last_next = fs;
			unique case (cfg_format)
				sai_fmt_lj:
				begin
					if (fs_chg)
					begin
						start_edge = 1'b1;
						cur_slot = fs ? 4'h0 : 4'h1;
					end
				end
				sai_fmt_rj:
				begin
				end
				sai_fmt_olm1, sai_fmt_olm2:
				begin
					// Sync and first MSB share this edge
					if (fs_up)
					begin
						start_edge = 1'b1;
						cur_slot = 4'h0;
					end
				end
				sai_fmt_tdm:
				begin
					// Sync is taken one edge ahead of the first MSB
					armed_next = fs_up;
					if (armed_reg)
					begin
						start_edge = 1'b1;
						cur_slot = 4'h0;
					end
				end
				// Unused format codes receive nothing
				default:
				begin
				end
			endcase
			if (start_edge)
				cur_pos = 6'h00;

			if (cfg_format == sai_fmt_rj)
			begin
				// The word is only known complete when sync flips, so the
				// low cfg_len bits of everything shifted in are the sample
				if (fs_chg && running_reg && pos_reg >= cfg_len)
				begin
					valid_next = 1'b1;
					data_next = shreg_reg & sai_len_mask(cfg_len);
					tag_next = fs_last_reg ? 4'h0 : 4'h1;
				end
				shreg_next = {shreg_reg[30:0], sd};
				if (fs_chg)
					pos_next = 6'h01;
				else if (pos_reg != `SAI_POS_MAX)
					pos_next = pos_reg + 6'h01;
				// The half in progress at reset is partial, skip it
				if (fs_chg)
					running_next = 1'b1;
			end
			else if (running_reg || start_edge)
			begin
				running_next = 1'b1;
				// Bits past the configured length are dropped
				if (cur_pos < cfg_len)
					shreg_next = {(cur_pos == 6'h00) ? 31'h0 : shreg_reg[30:0], sd};
				if (cur_pos == cfg_len - 6'h01 && cur_slot < slot_n)
				begin
					valid_next = 1'b1;
					data_next = shreg_next;
					tag_next = cur_slot;
				end
				slot_next = cur_slot;
				if (slot_w != 6'h00 && cur_pos == slot_w - 6'h01)
				begin
					pos_next = 6'h00;
					if (cur_slot != `SAI_SLOT_MAX)
						slot_next = cur_slot + 4'h1;
				end
				else if (cur_pos != `SAI_POS_MAX)
					pos_next = cur_pos + 6'h01;
				else
					pos_next = cur_pos;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sclk_prev_reg <= 1'b0;
			fs_last_reg <= 1'b0;
			armed_reg <= 1'b0;
			running_reg <= 1'b0;
			pos_reg <= 6'h00;
			slot_reg <= 4'h0;
			shreg_reg <= 32'h0;
			valid_reg <= 1'b0;
			data_reg <= 32'h0;
			tag_reg <= 4'h0;
		end
		else
		begin
			sclk_prev_reg <= sclk_prev_next;
			fs_last_reg <= fs_last_next;
			armed_reg <= armed_next;
			running_reg <= running_next;
			pos_reg <= pos_next;
			slot_reg <= slot_next;
			shreg_reg <= shreg_next;
			valid_reg <= valid_next;
			data_reg <= data_next;
			tag_reg <= tag_next;
		end
	end

	assign sample_valid = valid_reg;
	assign sample_data = data_reg;
	assign sample_slot = tag_reg;

	////////////////////////////////////////////////////////////////////////////
	// Master clock ratio

	sai_rate_detect u_rate
	(
		.clk(clk),
		.resetn(resetn),
		.mclk(link.audio_master_clock),
		.frame_tick(frame_tick),
		.mclk_ratio(mclk_ratio),
		.clk_div_sel(clk_div_sel),
		.mclk_rate_ok(mclk_rate_ok)
	);
endmodule

//--- sai_consts.svh
// Constants shared by both ends of the serial audio input port
`ifndef SAI_CONSTS_SVH
`define SAI_CONSTS_SVH

`define SAI_DATA_W 32
`define SAI_POS_MAX 6'h3f
`define SAI_SLOT_MAX 4'hf
`define SAI_SLOTW_STEREO 6'h00
`define SAI_SLOTW_OLM1 6'h14
`define SAI_SLOTW_OLM2 6'h18
`define SAI_SLOTW_TDM 6'h20
`define SAI_NSLOT_STEREO 4'h2
`define SAI_NSLOT_OLM1 4'h6
`define SAI_NSLOT_OLM2 4'ha
`define SAI_NSLOT_TDM 4'h8
`define SAI_FBITS_OLM1 9'h080
`define SAI_FBITS_256 9'h100
`define SAI_SYNC_HI_OLM1 9'h040
`define SAI_SYNC_HI_OLM2 9'h080
`define SAI_RATIO_MIN 16'h007f
`define SAI_RATIO_MAX 16'h0500
`define SAI_TH_192 16'h00a0
`define SAI_TH_256 16'h00e0
`define SAI_TH_384 16'h0140
`define SAI_TH_512 16'h01c0
`define SAI_TH_768 16'h0280
`define SAI_TH_1024 16'h0380

`endif

//--- sai_pkg.sv
// Types and format decoding shared by both ends
package sai_pkg;
`include "sai_consts.svh"

	typedef enum logic [2:0] {
		sai_fmt_lj = 3'h0,
		sai_fmt_rj = 3'h1,
		sai_fmt_olm1 = 3'h2,
		sai_fmt_olm2 = 3'h3,
		sai_fmt_tdm = 3'h4
	} sai_fmt_t;

	typedef enum logic [2:0] {
		sai_div_128 = 3'h0,
		sai_div_192 = 3'h1,
		sai_div_256 = 3'h2,
		sai_div_384 = 3'h3,
		sai_div_512 = 3'h4,
		sai_div_768 = 3'h5,
		sai_div_1024 = 3'h6
	} sai_div_t;

	// Zero width means the slot runs until the next sync edge
	function automatic logic [5:0] sai_slot_width(input sai_fmt_t fmt);
		unique case (fmt)
			sai_fmt_olm1: sai_slot_width = `SAI_SLOTW_OLM1;
			sai_fmt_olm2: sai_slot_width = `SAI_SLOTW_OLM2;
			sai_fmt_tdm: sai_slot_width = `SAI_SLOTW_TDM;
			default: sai_slot_width = `SAI_SLOTW_STEREO;
		endcase
	endfunction

	function automatic logic [3:0] sai_slot_count(input sai_fmt_t fmt);
		unique case (fmt)
			sai_fmt_olm1: sai_slot_count = `SAI_NSLOT_OLM1;
			sai_fmt_olm2: sai_slot_count = `SAI_NSLOT_OLM2;
			sai_fmt_tdm: sai_slot_count = `SAI_NSLOT_TDM;
			default: sai_slot_count = `SAI_NSLOT_STEREO;
		endcase
	endfunction

	function automatic logic [31:0] sai_len_mask(input logic [5:0] len);
		logic [32:0] m;
		m = (33'h1 << len) - 33'h1;
		sai_len_mask = m[31:0];
	endfunction
endpackage

//--- sai_link_if.sv
// Serial audio link between the source and the receiver
`timescale 1ns/1ns
interface sai_link_if;
	logic frame_sync_in;
	logic serial_bit_clock;
	logic serial_data_in;
	logic audio_master_clock;

	modport source
	(
		output frame_sync_in,
		output serial_bit_clock,
		output serial_data_in,
		output audio_master_clock
	);

	modport receiver
	(
		input frame_sync_in,
		input serial_bit_clock,
		input serial_data_in,
		input audio_master_clock
	);
endinterface

//--- sai_rate_detect.sv
// Master clock to frame rate ratio measurement and divider choice
`timescale 1ns/1ns
`include "sai_consts.svh"
module sai_rate_detect
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic mclk,
	input wire logic frame_tick,
	output logic [15:0] mclk_ratio,
	output sai_pkg::sai_div_t clk_div_sel,
	output logic mclk_rate_ok
);
	import sai_pkg::*;

	logic mclk_prev_reg, mclk_prev_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [15:0] ratio_reg, ratio_next;
	sai_div_t div_reg, div_next;
	logic ok_reg, ok_next;
	logic [15:0] cnt_now;

	always_comb
	begin
		mclk_prev_next = mclk;
		cnt_now = cnt_reg;
		if (mclk && !mclk_prev_reg && cnt_reg != 16'hffff)
			cnt_now = cnt_reg + 16'h0001;
		cnt_next = cnt_now;
		ratio_next = ratio_reg;
		div_next = div_reg;
		ok_next = ok_reg;
		if (frame_tick)
		begin
			cnt_next = 16'h0000;
			ratio_next = cnt_now;
			// Below the floor the converter clock cannot be derived
			ok_next = cnt_now >= `SAI_RATIO_MIN && cnt_now <= `SAI_RATIO_MAX;
			if (cnt_now < `SAI_TH_192)
				div_next = sai_div_128;
			else if (cnt_now < `SAI_TH_256)
				div_next = sai_div_192;
			else if (cnt_now < `SAI_TH_384)
				div_next = sai_div_256;
			else if (cnt_now < `SAI_TH_512)
				div_next = sai_div_384;
			else if (cnt_now < `SAI_TH_768)
				div_next = sai_div_512;
			else if (cnt_now < `SAI_TH_1024)
				div_next = sai_div_768;
			else
				div_next = sai_div_1024;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			mclk_prev_reg <= 1'b0;
			cnt_reg <= 16'h0000;
			ratio_reg <= 16'h0000;
			div_reg <= sai_div_128;
			ok_reg <= 1'b0;
		end
		else
		begin
			mclk_prev_reg <= mclk_prev_next;
			cnt_reg <= cnt_next;
			ratio_reg <= ratio_next;
			div_reg <= div_next;
			ok_reg <= ok_next;
		end
	end

	assign mclk_ratio = ratio_reg;
	assign clk_div_sel = div_reg;
	assign mclk_rate_ok = ok_reg;
endmodule

//--- sai_source.sv
// Sending end: builds the serial audio frame from supplied words
`timescale 1ns/1ns
`include "sai_consts.svh"
module sai_source
#(
	parameter logic [7:0] SCLK_HALF = 8'h04,
	parameter logic [7:0] MCLK_HALF = 8'h01
)
(
	input wire logic clk,
	input wire logic resetn,
	sai_link_if.source link,
	input wire sai_pkg::sai_fmt_t cfg_format,
	input wire logic [5:0] cfg_len,
	input wire logic [8:0] cfg_frame_bits,
	input wire logic [31:0] tx_data,
	output logic tx_take,
	output logic [3:0] tx_slot
);
	import sai_pkg::*;

	logic [7:0] sdiv_reg, sdiv_next;
	logic [7:0] mdiv_reg, mdiv_next;
	logic sclk_reg, sclk_next;
	logic mclk_reg, mclk_next;
	logic fs_reg, fs_next;
	logic sd_reg, sd_next;
	logic [8:0] idx_reg, idx_next;
	logic [8:0] pos_reg, pos_next;
	logic [3:0] slot_reg, slot_next;
	logic [31:0] shreg_reg, shreg_next;
	logic take_reg, take_next;
	logic [3:0] tslot_reg, tslot_next;

	logic [8:0] fbits;
	logic [8:0] half;
	logic [8:0] ws;
	logic [8:0] len9;
	logic two_ch;
	logic [31:0] aligned;

	assign two_ch = cfg_format == sai_fmt_lj || cfg_format == sai_fmt_rj;
	// Stereo ratio is the user's to choose within the allowed set
	assign fbits = two_ch ? cfg_frame_bits
		: (cfg_format == sai_fmt_olm1) ? `SAI_FBITS_OLM1 : `SAI_FBITS_256;
	assign half = {1'b0, fbits[8:1]};
	assign len9 = {3'h0, cfg_len};
	assign ws = (cfg_format == sai_fmt_rj) ? half - len9 : 9'h000;
	assign aligned = tx_data << (6'h20 - cfg_len);

	////////////////////////////////////////////////////////////////////////////
	// Bit clock, master clock and frame build

	always_comb
	begin
		sdiv_next = sdiv_reg + 8'h01;
		mdiv_next = mdiv_reg + 8'h01;
		sclk_next = sclk_reg;
		mclk_next = mclk_reg;
		fs_next = fs_reg;
		sd_next = sd_reg;
		idx_next = idx_reg;
		pos_next = pos_reg;
		slot_next = slot_reg;
		shreg_next = shreg_reg;
		take_next = 1'b0;
		tslot_next = tslot_reg;
		if (mdiv_reg == MCLK_HALF - 8'h01)
		begin
			mdiv_next = 8'h00;
			mclk_next = !mclk_reg;
		end
		if (sdiv_reg == SCLK_HALF - 8'h01)
		begin
			sdiv_next = 8'h00;
			sclk_next = !sclk_reg;
			// Lines change on the falling edge so they are stable at the rise
			if (sclk_reg)
			begin
				idx_next = (idx_reg >= fbits - 9'h001) ? 9'h000 : idx_reg + 9'h001;
				if (two_ch)
				begin
					slot_next = (idx_next >= half) ? 4'h1 : 4'h0;
					pos_next = (idx_next >= half) ? idx_next - half : idx_next;
					fs_next = idx_next < half;
				end
				else
				begin
					if (idx_next == 9'h000)
					begin
						pos_next = 9'h000;
						slot_next = 4'h0;
					end
					else if (pos_reg == {3'h0, sai_slot_width(cfg_format)} - 9'h001)
					begin
						pos_next = 9'h000;
						if (slot_reg != `SAI_SLOT_MAX)
							slot_next = slot_reg + 4'h1;
					end
					else
						pos_next = pos_reg + 9'h001;
					unique case (cfg_format)
						sai_fmt_olm1: fs_next = idx_next < `SAI_SYNC_HI_OLM1;
						sai_fmt_olm2: fs_next = idx_next < `SAI_SYNC_HI_OLM2;
						default: fs_next = idx_next == fbits - 9'h001;
					endcase
				end
				if (pos_next == ws && slot_next < sai_slot_count(cfg_format))
				begin
					sd_next = aligned[31];
					shreg_next = aligned << 1;
					take_next = 1'b1;
					tslot_next = slot_next;
				end
				else if (pos_next > ws && pos_next < ws + len9)
				begin
					sd_next = shreg_reg[31];
					shreg_next = shreg_reg << 1;
				end
				else
					sd_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sdiv_reg <= 8'h00;
			mdiv_reg <= 8'h00;
			sclk_reg <= 1'b0;
			mclk_reg <= 1'b0;
			fs_reg <= 1'b0;
			sd_reg <= 1'b0;
			idx_reg <= 9'h1ff;
			pos_reg <= 9'h000;
			slot_reg <= 4'h0;
			shreg_reg <= 32'h0;
			take_reg <= 1'b0;
			tslot_reg <= 4'h0;
		end
		else
		begin
			sdiv_reg <= sdiv_next;
			mdiv_reg <= mdiv_next;
			sclk_reg <= sclk_next;
			mclk_reg <= mclk_next;
			fs_reg <= fs_next;
			sd_reg <= sd_next;
			idx_reg <= idx_next;
			pos_reg <= pos_next;
			slot_reg <= slot_next;
			shreg_reg <= shreg_next;
			take_reg <= take_next;
			tslot_reg <= tslot_next;
		end
	end

	assign link.serial_bit_clock = sclk_reg;
	assign link.audio_master_clock = mclk_reg;
	assign link.frame_sync_in = fs_reg;
	assign link.serial_data_in = sd_reg;
	assign tx_take = take_reg;
	assign tx_slot = tslot_reg;
endmodule

//--- sai_link_checker.sv
// Assertions on the serial audio link and on the receiver's outputs
`timescale 1ns/1ns
module sai_link_checker
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic frame_sync_in,
	input wire logic serial_bit_clock,
	input wire logic serial_data_in,
	input wire sai_pkg::sai_fmt_t cfg_format,
	input wire logic sample_valid,
	input wire logic [3:0] sample_slot,
	input wire logic [15:0] mclk_ratio,
	input wire logic mclk_rate_ok
);
	import sai_pkg::*;
	logic sclk_q;
	logic sync_q;
	logic seen;
	logic [8:0] hi_rises;
	logic [8:0] fr_rises;
	logic [3:0] slot_lim;
	logic [8:0] frame_lim;
	logic one_line;
	assign one_line = (cfg_format == sai_fmt_olm1) || (cfg_format == sai_fmt_olm2);
	assign slot_lim = (cfg_format == sai_fmt_olm1) ? 4'h6 : (cfg_format == sai_fmt_olm2) ? 4'ha
		: (cfg_format == sai_fmt_tdm) ? 4'h8 : 4'h2;
	assign frame_lim = (cfg_format == sai_fmt_olm1) ? 9'h080 : 9'h100;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
////////////////////////////////////////////////////////////////
	// Counts restart at each sync rise; the first frame is partial, hence seen
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sclk_q <= 1'b0;
			sync_q <= 1'b0;
			seen <= 1'b0;
			hi_rises <= 9'h000;
			fr_rises <= 9'h000;
		end
		else
		begin
			sclk_q <= serial_bit_clock;
			sync_q <= frame_sync_in;
			if (frame_sync_in && !sync_q)
			begin
				seen <= 1'b1;
				hi_rises <= 9'h000;
				fr_rises <= 9'h000;
			end
			else if (serial_bit_clock && !sclk_q)
			begin
				fr_rises <= fr_rises + 9'h001;
				hi_rises <= hi_rises + {8'h00, frame_sync_in};
			end
		end
	end
////////////////////////////////////////////////////////////////
	a_data_on_fall: assert property
		($changed(serial_data_in) |-> !serial_bit_clock)
		else $error("serial data moved while bit clock high");
	a_sync_on_fall: assert property
		($changed(frame_sync_in) |-> !serial_bit_clock)
		else $error("frame sync moved while bit clock high");
	a_valid_one_cycle: assert property
		(sample_valid |=> !sample_valid)
		else $error("sample valid longer than one cycle");
	a_slot_in_range: assert property
		(sample_valid |-> sample_slot < slot_lim)
		else $error("sample slot beyond slot count");
	a_valid_after_rise: assert property
		($rose(sample_valid) |-> $past(serial_bit_clock) && !$past(serial_bit_clock, 2))
		else $error("sample valid not one cycle after a bit clock rise");
	a_sync_high_half: assert property
		((sync_q && !frame_sync_in && one_line) |-> hi_rises == {1'b0, frame_lim[8:1]})
		else $error("one-line sync high length wrong");
	a_frame_bit_count: assert property
		((frame_sync_in && !sync_q && seen && (one_line || cfg_format == sai_fmt_tdm))
		|-> fr_rises == frame_lim)
		else $error("bit clocks per frame wrong");
	a_tdm_sync_seen: assert property
		((sync_q && !frame_sync_in && cfg_format == sai_fmt_tdm) |-> hi_rises != 9'h000)
		else $error("tdm sync not held over a bit clock rise");
	a_rate_ok_range: assert property
		(mclk_rate_ok == (mclk_ratio >= 16'h007f && mclk_ratio <= 16'h0500))
		else $error("rate ok flag disagrees with ratio");
	a_ratio_at_frame: assert property
		($changed(mclk_ratio) |-> $past(serial_bit_clock) && !$past(serial_bit_clock, 2)
		&& $past(frame_sync_in))
		else $error("ratio updated away from a frame start");
endmodule

//--- tb.sv
// Self-checking bench: source and receiver joined over the serial audio link
`timescale 1ns/1ns
module tb;
	import sai_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	sai_fmt_t cfg_format = sai_fmt_lj;
	logic [5:0] cfg_len = 6'h10;
	logic [8:0] cfg_frame_bits = 9'h040;
	logic [31:0] tx_data = 32'h0;
	logic tx_take;
	logic [3:0] tx_slot;
	logic sample_valid;
	logic [31:0] sample_data;
	logic [3:0] sample_slot;
	logic [15:0] mclk_ratio;
	sai_div_t clk_div_sel;
	logic mclk_rate_ok;
	logic [3:0] last_slot = 4'h0;
	int fail_count = 0;
	int checks_done = 0;
	int got_count = 0;
	sai_link_if link();
	// Master clock period 4 clk, bit period 8 clk: ratio is twice the bits per frame
	sai_source #(.SCLK_HALF(8'h04), .MCLK_HALF(8'h02)) sai_source_inst
	(
		.clk(clk), .resetn(resetn), .link(link), .cfg_format(cfg_format), .cfg_len(cfg_len),
		.cfg_frame_bits(cfg_frame_bits), .tx_data(tx_data), .tx_take(tx_take), .tx_slot(tx_slot)
	);
	sai_receiver sai_receiver_inst
	(
		.clk(clk), .resetn(resetn), .link(link), .cfg_format(cfg_format), .cfg_len(cfg_len),
		.sample_valid(sample_valid), .sample_data(sample_data), .sample_slot(sample_slot),
		.mclk_ratio(mclk_ratio), .clk_div_sel(clk_div_sel), .mclk_rate_ok(mclk_rate_ok)
	);
	sai_link_checker sai_link_checker_inst
	(
		.clk(clk), .resetn(resetn), .frame_sync_in(link.frame_sync_in),
		.serial_bit_clock(link.serial_bit_clock), .serial_data_in(link.serial_data_in),
		.cfg_format(cfg_format), .sample_valid(sample_valid), .sample_slot(sample_slot),
		.mclk_ratio(mclk_ratio), .mclk_rate_ok(mclk_rate_ok)
	);
	always #5 clk = ~clk;
////////////////////////////////////////////////////////////////
	function automatic logic [3:0] slots_of(input sai_fmt_t f);
		case (f)
			sai_fmt_olm1: return 4'h6;
			sai_fmt_olm2: return 4'ha;
			sai_fmt_tdm: return 4'h8;
			default: return 4'h2;
		endcase
	endfunction
	// Slot number folded in, so a word landing in the wrong slot shows up
	function automatic logic [31:0] pat(input logic [3:0] s);
		logic [31:0] m;
		m = (cfg_len >= 6'h20) ? 32'hffff_ffff : ((32'h1 << cfg_len) - 32'h1);
		return (32'h5ac3_e169 ^ {8{s}}) & m;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		checks_done++;
		if (seen !== expected)
		begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask
	task automatic results;
		if (fail_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
////////////////////////////////////////////////////////////////
	// Next word is staged right after the source takes one; samples judged as they land
	always @(posedge clk)
	begin
		#1;
		if (tx_take === 1'b1)
			tx_data = pat((tx_slot + 4'h1) % slots_of(cfg_format));
		if (sample_valid === 1'b1)
		begin
			check(sample_data, pat(sample_slot));
			check(sample_slot < slots_of(cfg_format), 1'b1);
			if (got_count > 0)
				check(sample_slot, (last_slot + 4'h1) % slots_of(cfg_format));
			last_slot = sample_slot;
			got_count++;
		end
	end
	// Format and length are used live, not latched, so each scenario changes them under reset
	task automatic start(input sai_fmt_t f, input logic [5:0] len, input logic [8:0] fb);
		@(posedge clk);
		#1;
		resetn = 1'b0;
		cfg_format = f;
		cfg_len = len;
		cfg_frame_bits = fb;
		tx_data = pat(4'h0);
		repeat (20) @(posedge clk);
		#1;
		got_count = 0;
		resetn = 1'b1;
	endtask
	task automatic finish_run(input int want, input sai_div_t d, input logic ok);
		int n;
		n = 0;
		while (got_count < want && n < 12000)
		begin
			@(posedge clk);
			n++;
		end
		// Look after the edge so the registered outputs have settled
		#1;
		check(got_count >= want, 1'b1);
		check(mclk_ratio, {6'h00, cfg_frame_bits, 1'b0});
		check(clk_div_sel, d);
		check(mclk_rate_ok, ok);
	endtask
////////////////////////////////////////////////////////////////
	// Shortest stereo frame; master clock only 64 per frame, so rate is flagged bad
	task automatic t_lj_32fs;
		start(sai_fmt_lj, 6'h10, 9'h020);
		finish_run(6, sai_div_128, 1'b0);
	endtask
	task automatic t_lj24_64fs;
		start(sai_fmt_lj, 6'h18, 9'h040);
		finish_run(6, sai_div_128, 1'b1);
	endtask
	task automatic t_rj16_128fs;
		start(sai_fmt_rj, 6'h10, 9'h080);
		finish_run(6, sai_div_256, 1'b1);
	endtask
	// A 24-bit word fills the whole 24-bit half, leaving no lead-in
	task automatic t_rj24_48fs;
		start(sai_fmt_rj, 6'h18, 9'h030);
		finish_run(6, sai_div_128, 1'b0);
	endtask
	task automatic t_olm1_18;
		start(sai_fmt_olm1, 6'h12, 9'h080);
		finish_run(14, sai_div_256, 1'b1);
	endtask
	task automatic t_olm2_20;
		start(sai_fmt_olm2, 6'h14, 9'h100);
		finish_run(22, sai_div_512, 1'b1);
	endtask
	task automatic t_tdm_32;
		start(sai_fmt_tdm, 6'h20, 9'h100);
		finish_run(18, sai_div_512, 1'b1);
	endtask
	initial
	begin
		t_lj_32fs();
		t_lj24_64fs();
		t_rj16_128fs();
		t_rj24_48fs();
		t_olm1_18();
		t_olm2_20();
		t_tdm_32();
		results();
	end
	// All scenarios need about 20k cycles; 60k means something hangs
	initial
	begin
		#600000;
		fail_count++;
		$display("MISMATCH at %0t: run timed out", $time);
		results();
	end
endmodule
